// ---- include/hmap_params.svh ----
`ifndef HMAP_PARAMS_SVH
`define HMAP_PARAMS_SVH
// Instruction clock period tCK in ns and the 40 MHz system clock period in ns
`define HMAP_TCK_NS 100
`define HMAP_CLK_NS 25
// 1.5 tCK least write busy time, rounded up to whole cycles
`define HMAP_WR_BUSY_CYC ((3 * `HMAP_TCK_NS + 2 * `HMAP_CLK_NS - 1) / (2 * `HMAP_CLK_NS))
// 0.5 tCK least data setup before acknowledge low, rounded up
`define HMAP_RD_SETUP_CYC ((`HMAP_TCK_NS + 2 * `HMAP_CLK_NS - 1) / (2 * `HMAP_CLK_NS))
// Internal memory fetch latency in cycles
`define HMAP_FETCH_CYC 2
// Overlay register control bit for short-read-only mode
`define HMAP_SRO_BIT 14
`define HMAP_SRO_RST 1'b0
`define HMAP_OVL_ADDR 16'h3fe7
`define HMAP_FIFO_DEPTH 16
`endif

// ---- include/hmap_pkg.sv ----
package hmap_pkg;
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_WRITE,
    ACC_READ
  } acc_kind_t;
  typedef logic [15:0] word_t;
endpackage

// ---- hdl/hmap_port.sv ----
`timescale 1ns/1ps
`include "hmap_params.svh"

module hmap_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= in_data;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Function
// R01: Host starts a write only once acknowledge reads low.
// R02: Device raises acknowledge (busy) promptly after a write starts; the code leaves it low and drops the write when the FIFO is full.
// R03: Long write: acknowledge returns low no sooner than 1.5 tCK after start.
// R04: Strobe ending before or after acknowledge low selects short or long data timing.
// R05: Short write: host holds strobe a minimum time with data presented.
// R06: Host starts a read only once acknowledge reads low.
// R07: Read start drives prefetched word, then acknowledge goes busy during next fetch.
// R08: Long read: new data on bus at least 0.5 tCK before acknowledge low.
// R09: Long read: host ends read only after acknowledge is low.
// R10: Program word reads as two halves; data word is one read.
// R11: Short read: host ends each read within its maximum duration.
// R12: Device releases the bus promptly after a read ends.
// R13: Overlay bit 14 enables short-read-only mode; cleared at reset.
// R14: Hosts should prefer short-read-only mode over short reads.
// R15: Host finishes address latching before starting an access.
// R16: Core and host can both write the short-read-only bit.
// R17: Access starts with select and strobe low, ends when either rises.
module hmap_port
  import hmap_pkg::*;
#(
  parameter int FIFO_DEPTH = `HMAP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic port_select_n,
  input wire logic port_write_strobe_n,
  input wire logic port_read_strobe_n,
  input wire logic port_address_latch,
  input wire hmap_pkg::word_t port_addr_data_bus_in,
  output hmap_pkg::word_t port_addr_data_bus_out,
  output logic port_addr_data_bus_oe,
  output logic port_acknowledge_n,
  input wire logic core_ovl_we,
  input wire logic core_ovl_sro,
  output logic short_read_only,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output hmap_pkg::word_t mem_wr_addr,
  output logic mem_wr_prog,
  output logic mem_wr_half,
  output hmap_pkg::word_t mem_wr_data,
  output logic mem_rd_req,
  output hmap_pkg::word_t mem_rd_addr,
  output logic mem_rd_half,
  input wire hmap_pkg::word_t mem_rd_data
);
  import hmap_pkg::*;

  localparam int WR_CYC = `HMAP_WR_BUSY_CYC;
  localparam int RD_CYC = `HMAP_FETCH_CYC + `HMAP_RD_SETUP_CYC;

  typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD, ST_WAIT_END} state_t;

  state_t st_r;
  acc_kind_t kind_r;
  logic [7:0] cnt_r;
  word_t addr_r;
  word_t prev_r;
  word_t bus_out_r;
  logic oe_r;
  logic ack_n_r;
  logic sro_r;
  logic half_r;
  logic in_acc_r;
  logic rd_req_r;
  logic fifo_ready;
  logic fifo_out_valid;
  logic [33:0] fifo_out;

  // Address bit 15 picks program memory; below that is the word address
  wire is_prog = addr_r[15];
  wire wr_act = !port_select_n && !port_write_strobe_n; // [R17]
  wire rd_act = !port_select_n && !port_read_strobe_n; // [R17]
  wire latch_act = !port_select_n && port_address_latch;
  wire acc_start = (wr_act || rd_act) && !in_acc_r;
  wire acc_end = in_acc_r && !wr_act && !rd_act;
  wire ovl_hit = addr_r == `HMAP_OVL_ADDR;
  wire host_ovl_we = acc_start && wr_act && ovl_hit;
  // Writes arriving while the FIFO is full are dropped and acknowledge stays low
  wire wr_push = acc_start && wr_act && !ovl_hit && fifo_ready && ack_n_r == 1'b0;
  wire next_half = is_prog && !half_r;

  hmap_fifo #(.WIDTH(34), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr_push),
    .in_ready(fifo_ready),
    .in_data({is_prog, half_r, addr_r[14:0], 1'b0, port_addr_data_bus_in}),
    .out_valid(fifo_out_valid),
    .out_ready(mem_wr_ready),
    .out_data(fifo_out)
  );
  assign mem_wr_valid = fifo_out_valid;
  assign mem_wr_prog = fifo_out[33];
  assign mem_wr_half = fifo_out[32];
  assign mem_wr_addr = {1'b0, fifo_out[31:17]};
  assign mem_wr_data = fifo_out[15:0];
  // Bit 15 stays on the read address: it is the only program/data select the memory sees
  assign mem_rd_addr = addr_r;
  assign mem_rd_half = half_r;
  assign mem_rd_req = rd_req_r;

  assign port_addr_data_bus_out = bus_out_r;
  assign port_addr_data_bus_oe = oe_r;
  assign port_acknowledge_n = ack_n_r;
  assign short_read_only = sro_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      in_acc_r <= 1'b0;
    end else begin
      in_acc_r <= wr_act || rd_act;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sro_r <= `HMAP_SRO_RST; // [R13]
    end else if (host_ovl_we) begin
      sro_r <= port_addr_data_bus_in[`HMAP_SRO_BIT]; // [R16]
    end else if (core_ovl_we) begin
      sro_r <= core_ovl_sro; // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= '0;
      half_r <= 1'b0;
    end else if (latch_act && st_r == ST_IDLE) begin
      addr_r <= port_addr_data_bus_in;
      half_r <= 1'b0;
    end else if (acc_end && kind_r != ACC_NONE && !ovl_hit) begin
      // Program words take two halves before the address advances
      half_r <= next_half; // [R10]
      if (!next_half) addr_r <= addr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      kind_r <= ACC_NONE;
      cnt_r <= '0;
      ack_n_r <= 1'b0;
      oe_r <= 1'b0;
      bus_out_r <= '0;
      prev_r <= '0;
      rd_req_r <= 1'b0;
    end else begin
      rd_req_r <= 1'b0;
      if (acc_end) begin
        oe_r <= 1'b0; // [R12]
        kind_r <= ACC_NONE;
      end
      unique case (st_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (acc_start && wr_act && (wr_push || host_ovl_we)) begin
            ack_n_r <= 1'b1; // [R02]
            kind_r <= ACC_WRITE;
            st_r <= ST_WR;
          end else if (acc_start && rd_act) begin
            bus_out_r <= ovl_hit ? {1'b0, sro_r, 14'h0000} : prev_r; // [R07]
            oe_r <= 1'b1; // [R07]
            ack_n_r <= 1'b1; // [R07]
            rd_req_r <= 1'b1; // [R10]
            kind_r <= ACC_READ;
            st_r <= ST_RD;
          end
        end
        ST_WR: begin
          cnt_r <= cnt_r + 8'h01;
          // Full WR_CYC cycles from the sampling edge, as the strobe may fall just before it
          if (cnt_r == 8'(WR_CYC - 1)) begin
            ack_n_r <= 1'b0; // [R03] [R04]
            st_r <= ST_WAIT_END;
          end
        end
        ST_RD: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(`HMAP_FETCH_CYC - 1)) begin
            prev_r <= mem_rd_data;
            // Long read outside short-read-only mode shows fresh data; a short read has already ended
            if (rd_act && !sro_r) bus_out_r <= mem_rd_data; // [R08]
          end
          if (cnt_r == 8'(RD_CYC - 1)) begin
            ack_n_r <= 1'b0; // [R08]
            st_r <= ST_WAIT_END;
          end
        end
        ST_WAIT_END: begin
          if (!wr_act && !rd_act) st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- bench/hmap_port_chk.sv ----
`timescale 1ns/1ps
module hmap_port_chk
  import hmap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic port_select_n,
  input wire logic port_write_strobe_n,
  input wire logic port_read_strobe_n,
  input wire hmap_pkg::word_t port_addr_data_bus_out,
  input wire logic port_addr_data_bus_oe,
  input wire logic port_acknowledge_n,
  input wire logic core_ovl_we,
  input wire logic core_ovl_sro,
  input wire logic short_read_only,
  input wire logic mem_rd_req
);
  import hmap_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_on = !port_select_n && !port_write_strobe_n;
  wire logic rd_on = !port_select_n && !port_read_strobe_n;
  wire logic rd_go = rd_on && !port_acknowledge_n && !port_addr_data_bus_oe;
  wr_cycle_a: assert property ($rose(port_acknowledge_n) && wr_on |->
    port_acknowledge_n [*6] ##1 !port_acknowledge_n) else $error("write busy span wrong");
  rd_prev_a: assert property (rd_go |=> (port_addr_data_bus_oe && port_acknowledge_n)
    ##1 port_acknowledge_n [*3] ##1 !port_acknowledge_n) else $error("read busy span wrong");
  rd_setup_a: assert property ($fell(port_acknowledge_n) && port_addr_data_bus_oe |->
    $past(port_addr_data_bus_out, 2) == port_addr_data_bus_out) else $error("late read data");
  rd_fetch_a: assert property (rd_go |-> ##[1:2] mem_rd_req) else $error("no fetch");
  bus_free_a: assert property (port_addr_data_bus_oe && !rd_on |=>
    !port_addr_data_bus_oe) else $error("bus held after read");
  sro_rst_a: assert property ($past(rst) |-> !short_read_only) else $error("mode set");
  core_sro_a: assert property (core_ovl_we && port_select_n |=>
    short_read_only == $past(core_ovl_sro)) else $error("core mode write lost");
  idle_quiet_a: assert property (port_select_n |=> !$rose(port_acknowledge_n))
    else $error("busy without access");
  cover property (rd_go);
  cover property ($rose(port_acknowledge_n) && wr_on);
  cover property ($rose(short_read_only));
  cover property (rd_go ##2 !rd_on);
endmodule

// ---- bench/hmap_host.sv ----
`timescale 1ns/1ps
module hmap_host
  import hmap_pkg::*;
(
  input wire logic clk,
  input wire logic ack_n,
  input wire logic oe,
  input wire hmap_pkg::word_t dout,
  output logic sel_n,
  output logic wr_n,
  output logic rd_n,
  output logic al,
  output hmap_pkg::word_t bus
);
  import hmap_pkg::*;
  word_t hd = 16'h0;
  int n;
  // Released host lines show the inverse of the last value so stale data cannot match
  assign bus = oe ? dout : hd;
  initial {sel_n, wr_n, rd_n, al} = 4'he;
  task automatic idle();
    for (n = 0; n < 20 && ack_n !== 1'b0; n++) @(posedge clk);
    #3;
  endtask
  task automatic lat(input word_t a);
    idle();
    {sel_n, al} = 2'b01;
    hd = a;
    @(posedge clk);
    #3 {sel_n, al} = 2'b10;
    hd = ~a;
    @(posedge clk);
  endtask
  task automatic wr(input word_t d, input logic lng);
    idle();
    {sel_n, wr_n} = 2'b00;
    hd = d;
    repeat (2) @(posedge clk);
    for (n = 0; lng && n < 20 && ack_n !== 1'b0; n++) @(posedge clk);
    #3 {sel_n, wr_n} = 2'b11;
    hd = ~d;
    @(posedge clk);
  endtask
  task automatic rd(output word_t prv, output word_t nw);
    idle();
    {sel_n, rd_n} = 2'b00;
    repeat (2) @(posedge clk);
    prv = bus;
    for (n = 0; n < 20 && ack_n !== 1'b0; n++) @(posedge clk);
    nw = bus;
    #3 {sel_n, rd_n} = 2'b11;
    repeat (2) @(posedge clk);
  endtask
  // Short read: ends two cycles after start, before acknowledge returns low
  task automatic rds(output word_t prv);
    idle();
    {sel_n, rd_n} = 2'b00;
    repeat (2) @(posedge clk);
    prv = bus;
    #3 {sel_n, rd_n} = 2'b11;
    for (n = 0; n < 20 && ack_n !== 1'b0; n++) @(posedge clk);
    @(posedge clk);
  endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  import hmap_pkg::*;
  logic clk = 0, rst = 1, wrdy = 1, cwe = 0, csro = 0;
  int error_cnt = 0, compares = 0;
  word_t bin, bout, waddr, wdata, raddr, rdata, p, v;
  logic oe, ack_n, sel_n, wr_n, rd_n, al, sro, wval, rhalf;
  logic [31:0] q[$];
  always #12.5 clk = ~clk;
  function automatic word_t mem(word_t a, logic h);
    return {a[7:0], a[15:8]} ^ {15'h0, h};
  endfunction
  assign rdata = mem(raddr, rhalf);
  always @(posedge clk) if (wval && wrdy) q.push_back({waddr, wdata});
  hmap_port dut (.clk, .rst, .port_select_n(sel_n), .port_write_strobe_n(wr_n),
    .port_read_strobe_n(rd_n), .port_address_latch(al), .port_addr_data_bus_in(bin),
    .port_addr_data_bus_out(bout), .port_addr_data_bus_oe(oe), .port_acknowledge_n(ack_n),
    .core_ovl_we(cwe), .core_ovl_sro(csro), .short_read_only(sro), .mem_wr_valid(wval),
    .mem_wr_ready(wrdy), .mem_wr_addr(waddr), .mem_wr_prog(), .mem_wr_half(),
    .mem_wr_data(wdata), .mem_rd_req(), .mem_rd_addr(raddr), .mem_rd_half(rhalf),
    .mem_rd_data(rdata));
  hmap_host h (.clk, .ack_n, .oe, .dout(bout), .sel_n, .wr_n, .rd_n, .al, .bus(bin));
  task automatic t_wr();
    logic [31:0] w0, w1;
    h.lat(16'h0012);
    h.wr(16'ha5c3, 1);
    h.wr(16'h3c96, 0);
    repeat (4) @(posedge clk);
    w0 = q.pop_front();
    w1 = q.pop_front();
    `CHK("long wr", {16'h0012, 16'ha5c3}, w0)
    `CHK("short wr", {16'h0013, 16'h3c96}, w1)
    $display("t_wr end");
  endtask
  task automatic t_rd();
    h.lat(16'h0020);
    h.rd(p, v);
    `CHK("dm new", mem(16'h0020, 0), v)
    h.rd(p, v);
    `CHK("dm prev", mem(16'h0020, 0), p)
    `CHK("dm next", mem(16'h0021, 0), v)
    h.lat(16'h8040);
    h.rd(p, v);
    `CHK("pm lo", mem(16'h8040, 0), v)
    h.rd(p, v);
    `CHK("pm hi", mem(16'h8040, 1), v)
    h.rd(p, v);
    `CHK("pm next", mem(16'h8041, 0), v)
    `CHK("bus free", 1'b0, oe)
    $display("t_rd end");
  endtask
  task automatic t_ovl();
    `CHK("mode rst", 1'b0, sro)
    #3 cwe = 1;
    csro = 1;
    @(posedge clk);
    #3 cwe = 0;
    `CHK("core set", 1'b1, sro)
    h.lat(16'h3fe7);
    h.wr(16'h0000, 1);
    `CHK("host clr", 1'b0, sro)
    `CHK("no push", 0, q.size())
    $display("t_ovl end");
  endtask
  task automatic t_srd();
    h.lat(16'h3fe7);
    h.wr(16'h4000, 0);
    `CHK("host set", 1'b1, sro)
    h.lat(16'h0030);
    h.rds(p);
    `CHK("sro first", mem(16'h8041, 0), p)
    h.rds(p);
    `CHK("sro prev", mem(16'h0030, 0), p)
    `CHK("sro free", 1'b0, oe)
    h.lat(16'h3fe7);
    h.rds(p);
    `CHK("mode read", 16'h4000, p)
    $display("t_srd end");
  endtask
  task automatic t_fifo();
    #3 wrdy = 0;
    h.lat(16'h0100);
    for (int i = 0; i < 17; i++) h.wr(16'(i), 1);
    `CHK("full ack", 1'b0, ack_n)
    #3 wrdy = 1;
    repeat (20) @(posedge clk);
    `CHK("fifo cnt", 16, q.size())
    `CHK("fifo last", {16'h010f, 16'h000f}, q[15])
    $display("t_fifo end");
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    #3 rst = 0;
    t_wr();
    t_rd();
    t_ovl();
    t_srd();
    t_fifo();
    wrap_up();
  end
endmodule
bind hmap_port hmap_port_chk chk (.clk, .rst, .port_select_n, .port_write_strobe_n,
  .port_read_strobe_n, .port_addr_data_bus_out, .port_addr_data_bus_oe,
  .port_acknowledge_n, .core_ovl_we, .core_ovl_sro, .short_read_only, .mem_rd_req);
